// ### core/edc_defines.vh
`ifndef EDC_DEFINES_VH
`define EDC_DEFINES_VH
// timing at 200 MHz, 5 ns per cycle
`define EDC_CLK_NS          5
`define EDC_PWRUP_US        200
`define EDC_PWRUP_CYC       ((`EDC_PWRUP_US * 1000) / `EDC_CLK_NS)
`define EDC_INIT_CYCLES     4'h8
`define EDC_REF_MS          16
`define EDC_REF_ROWS        1024
`define EDC_REF_INT_CYC     (((`EDC_REF_MS * 1000000) / `EDC_CLK_NS) / `EDC_REF_ROWS)
`define EDC_T_PHASE_NS      20
`define EDC_T_PHASE_CYC     ((`EDC_T_PHASE_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_T_RAS_NS        60
`define EDC_T_RAS_CYC       ((`EDC_T_RAS_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_T_ACC_NS        60
`define EDC_T_ACC_CYC       ((`EDC_T_ACC_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_T_RP_NS         40
`define EDC_T_RP_CYC        ((`EDC_T_RP_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_ADDR_W          10
`define EDC_CNT_W           18
`define EDC_ROW_MSB         19
`define EDC_ROW_LSB         10
`define EDC_COL_MSB         9
`define EDC_COL_LSB         0
`define EDC_LO_MSB          7
`define EDC_HI_LSB          8
`endif

// ### core/edc_ctrl.v
`include "edc_defines.vh"
`default_nettype none
module edc_ctrl #(
    parameter PWRUP_CYC = `EDC_PWRUP_CYC,
    parameter REF_INT_CYC = `EDC_REF_INT_CYC
) (
    // clock and reset
    input  wire        mclk_in,
    input  wire        rst_b_in,
    // user request port
    input  wire        req_valid_in,
    input  wire        req_write_in,
    input  wire [19:0] req_addr_in,
    input  wire [15:0] req_wdata_in,
    input  wire [1:0]  req_byte_en_in,
    input  wire        req_page_in,
    output reg         req_ready_out,
    output reg         rd_valid_out,
    output reg  [15:0] rd_data_out,
    output reg         init_done_out,
    // memory pins
    output reg         row_strobe_n_out,
    output reg         low_byte_col_strobe_n_out,
    output reg         high_byte_col_strobe_n_out,
    output reg         write_strobe_n_out,
    output reg         out_enable_n_out,
    output reg  [9:0]  mux_addr_lines_out,
    input  wire [15:0] data_lines_in,
    output reg  [15:0] data_lines_out,
    output reg  [1:0]  data_lines_oe_n_out
);

    localparam [3:0] ST_PWRUP = 4'h0;
    localparam [3:0] ST_INIT  = 4'h1;
    localparam [3:0] ST_IDLE  = 4'h2;
    localparam [3:0] ST_ROW   = 4'h3;
    localparam [3:0] ST_COL   = 4'h4;
    localparam [3:0] ST_CEND  = 4'h5;
    localparam [3:0] ST_OPEN  = 4'h6;
    localparam [3:0] ST_CBR1  = 4'h7;
    localparam [3:0] ST_CBR2  = 4'h8;
    localparam [3:0] ST_PRE   = 4'h9;

    // wait loads cut to the counter width on purpose
    localparam [`EDC_CNT_W-1:0] T_PHASE = `EDC_T_PHASE_CYC;
    localparam [`EDC_CNT_W-1:0] T_RAS   = `EDC_T_RAS_CYC;
    localparam [`EDC_CNT_W-1:0] T_ACC   = `EDC_T_ACC_CYC;
    localparam [`EDC_CNT_W-1:0] T_RP    = `EDC_T_RP_CYC;

    reg [3:0]               state_q;
    reg [`EDC_CNT_W-1:0]    wait_q;
    reg [`EDC_CNT_W-1:0]    ref_tmr_q;
    reg                     ref_due_q;
    reg [3:0]               init_cnt_q;
    reg [`EDC_ADDR_W-1:0]   open_row_q;
    reg                     is_wr_q;
    reg [1:0]               be_q;
    reg [`EDC_ADDR_W-1:0]   col_q;
    reg [15:0]              wdata_q;

    wire wait_done = (wait_q == {`EDC_CNT_W{1'b0}});
    wire req_hit = req_valid_in && req_ready_out;
    wire same_row = req_addr_in[`EDC_ROW_MSB:`EDC_ROW_LSB] == open_row_q;

    // refresh pacing: one row every 16 ms / 1024; a due refresh waits for idle
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ref_tmr_q <= {`EDC_CNT_W{1'b0}};
            ref_due_q <= 1'b0;
        end else begin
            if (ref_tmr_q == REF_INT_CYC[`EDC_CNT_W-1:0] - 1'b1) begin
                ref_tmr_q <= {`EDC_CNT_W{1'b0}};
                ref_due_q <= 1'b1;
            end else begin
                ref_tmr_q <= ref_tmr_q + 1'b1;
                if (state_q == ST_CBR2 && wait_done)
                    ref_due_q <= 1'b0;
            end
        end
    end

    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q                    <= ST_PWRUP;
            wait_q                     <= {`EDC_CNT_W{1'b0}};
            init_cnt_q                 <= 4'h0;
            open_row_q                 <= {`EDC_ADDR_W{1'b0}};
            is_wr_q                    <= 1'b0;
            be_q                       <= 2'h0;
            col_q                      <= {`EDC_ADDR_W{1'b0}};
            wdata_q                    <= 16'h0000;
            req_ready_out              <= 1'b0;
            rd_valid_out               <= 1'b0;
            rd_data_out                <= 16'h0000;
            init_done_out              <= 1'b0;
            row_strobe_n_out           <= 1'b1;
            low_byte_col_strobe_n_out  <= 1'b1;
            high_byte_col_strobe_n_out <= 1'b1;
            write_strobe_n_out         <= 1'b1;
            out_enable_n_out           <= 1'b1;
            mux_addr_lines_out         <= {`EDC_ADDR_W{1'b0}};
            data_lines_out             <= 16'h0000;
            data_lines_oe_n_out        <= 2'h3;
        end else begin
            rd_valid_out <= 1'b0;
            if (!wait_done)
                wait_q <= wait_q - 1'b1;
            case (state_q)
            ST_PWRUP: begin
                // power-up pause before any row strobe
                if (wait_q == {`EDC_CNT_W{1'b0}} && init_cnt_q == 4'h0) begin
                    wait_q     <= PWRUP_CYC[`EDC_CNT_W-1:0];
                    init_cnt_q <= 4'h1;
                end else if (wait_done) begin
                    init_cnt_q <= 4'h0;
                    state_q    <= ST_INIT;
                end
            end
            ST_INIT: begin
                // eight row-only cycles, strobes otherwise idle; data released
                if (wait_done) begin
                    if (row_strobe_n_out) begin
                        if (init_cnt_q == `EDC_INIT_CYCLES) begin
                            init_done_out <= 1'b1;
                            req_ready_out <= 1'b1;
                            state_q       <= ST_IDLE;
                        end else begin
                            mux_addr_lines_out <= {{(`EDC_ADDR_W-4){1'b0}}, init_cnt_q};
                            row_strobe_n_out   <= 1'b0;
                            wait_q <= T_RAS;
                        end
                    end else begin
                        row_strobe_n_out <= 1'b1;
                        init_cnt_q       <= init_cnt_q + 1'b1;
                        wait_q <= T_RP;
                    end
                end
            end
            ST_IDLE: begin
                // a request met by a raised ready is taken before a due refresh
                if (req_hit) begin
                    req_ready_out      <= 1'b0;
                    is_wr_q            <= req_write_in;
                    be_q               <= req_byte_en_in;
                    col_q              <= req_addr_in[`EDC_COL_MSB:`EDC_COL_LSB];
                    wdata_q            <= req_wdata_in;
                    open_row_q         <= req_addr_in[`EDC_ROW_MSB:`EDC_ROW_LSB];
                    mux_addr_lines_out <= req_addr_in[`EDC_ROW_MSB:`EDC_ROW_LSB];
                    row_strobe_n_out   <= 1'b0;
                    wait_q  <= T_PHASE;
                    state_q <= ST_ROW;
                end else if (ref_due_q) begin
                    // column strobes fall first, then the row strobe
                    req_ready_out              <= 1'b0;
                    low_byte_col_strobe_n_out  <= 1'b0;
                    high_byte_col_strobe_n_out <= 1'b0;
                    wait_q  <= T_PHASE;
                    state_q <= ST_CBR1;
                end
            end
            ST_ROW: begin
                // column half follows the row half; the requester is free once taken
                if (wait_done) begin
                    mux_addr_lines_out <= col_q;
                    if (is_wr_q) begin
                        write_strobe_n_out  <= 1'b0;
                        data_lines_out      <= wdata_q;
                        data_lines_oe_n_out <= ~be_q;
                    end else
                        out_enable_n_out <= 1'b0;
                    wait_q  <= T_PHASE;
                    state_q <= ST_COL;
                end
            end
            ST_COL: begin
                if (wait_done) begin
                    // only enabled bytes strobe: one for a single-byte access, both for a full word
                    low_byte_col_strobe_n_out  <= ~be_q[0];
                    high_byte_col_strobe_n_out <= ~be_q[1];
                    wait_q  <= T_ACC;
                    state_q <= ST_CEND;
                end
            end
            ST_CEND: begin
                if (wait_done) begin
                    if (!is_wr_q) begin
                        // lanes of unselected bytes are released and read back zero
                        rd_data_out[`EDC_LO_MSB:0] <= be_q[0] ?
                            data_lines_in[`EDC_LO_MSB:0] : 8'h00;
                        rd_data_out[15:`EDC_HI_LSB] <= be_q[1] ?
                            data_lines_in[15:`EDC_HI_LSB] : 8'h00;
                        rd_valid_out <= 1'b1;
                    end
                    low_byte_col_strobe_n_out  <= 1'b1;
                    high_byte_col_strobe_n_out <= 1'b1;
                    write_strobe_n_out         <= 1'b1;
                    data_lines_oe_n_out        <= 2'h3;
                    wait_q  <= T_PHASE;
                    state_q <= ST_OPEN;
                end
            end
            ST_OPEN: begin
                // ready rises only for a waiting page hit, so a raised ready always
                // ends in a take; a miss or a due refresh closes the row instead
                if (req_hit) begin
                    req_ready_out      <= 1'b0;
                    is_wr_q            <= req_write_in;
                    be_q               <= req_byte_en_in;
                    mux_addr_lines_out <= req_addr_in[`EDC_COL_MSB:`EDC_COL_LSB];
                    write_strobe_n_out <= ~req_write_in;
                    out_enable_n_out   <= req_write_in;
                    data_lines_out     <= req_wdata_in;
                    data_lines_oe_n_out <= req_write_in ? ~req_byte_en_in : 2'h3;
                    wait_q  <= T_PHASE;
                    state_q <= ST_COL;
                end else if (ref_due_q || (req_valid_in && !(req_page_in && same_row))) begin
                    row_strobe_n_out <= 1'b1;
                    out_enable_n_out <= 1'b1;
                    wait_q  <= T_RP;
                    state_q <= ST_PRE;
                end else if (req_valid_in && wait_done)
                    req_ready_out <= 1'b1;
            end
            ST_CBR1: begin
                if (wait_done) begin
                    row_strobe_n_out <= 1'b0;
                    wait_q  <= T_RAS;
                    state_q <= ST_CBR2;
                end
            end
            ST_CBR2: begin
                // short low time keeps the device out of self refresh
                if (wait_done) begin
                    row_strobe_n_out           <= 1'b1;
                    low_byte_col_strobe_n_out  <= 1'b1;
                    high_byte_col_strobe_n_out <= 1'b1;
                    wait_q  <= T_RP;
                    state_q <= ST_PRE;
                end
            end
            ST_PRE: begin
                if (wait_done) begin
                    req_ready_out <= !ref_due_q;
                    state_q       <= ST_IDLE;
                end
            end
            default: state_q <= ST_IDLE;
            endcase
        end
    end

endmodule // edc_ctrl
`default_nettype wire

// ### tb/edc_ctrl_assertions.sv
`default_nettype none
module edc_ctrl_assertions #(
    parameter REF_INT_CYC = 200
) (
    // clock, reset and user side
    input wire logic        mclk_in,
    input wire logic        rst_b_in,
    input wire logic        req_ready_out,
    input wire logic        rd_valid_out,
    input wire logic        init_done_out,
    // memory pins
    input wire logic        row_strobe_n_out,
    input wire logic        low_byte_col_strobe_n_out,
    input wire logic        high_byte_col_strobe_n_out,
    input wire logic        write_strobe_n_out,
    input wire logic        out_enable_n_out,
    input wire logic [9:0]  mux_addr_lines_out,
    input wire logic [1:0]  data_lines_oe_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    wire row = !row_strobe_n_out;
    wire lo  = !low_byte_col_strobe_n_out;
    wire hi  = !high_byte_col_strobe_n_out;
    int  gap_q;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    // slack covers an access that holds the refresh off
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            gap_q <= 0;
        end else if (!init_done_out || ($fell(row_strobe_n_out) && (lo || hi))) begin
            gap_q <= 0;
        end else begin
            gap_q <= gap_q + 1;
        end
    end
    a_refresh_gap: assert property (gap_q <= REF_INT_CYC + 64)
        else $error("refresh interval overrun");
    a_standby_released: assert property (!row && !lo && !hi |-> data_lines_oe_n_out == 2'b11)
        else $error("data driven in standby");
    a_read_no_drive: assert property (!out_enable_n_out |-> data_lines_oe_n_out == 2'b11)
        else $error("data driven while device output on");
    a_low_write_drive: assert property (row && lo && !write_strobe_n_out |-> !data_lines_oe_n_out[0])
        else $error("low byte not driven in write");
    a_high_write_drive: assert property (row && hi && !write_strobe_n_out |-> !data_lines_oe_n_out[1])
        else $error("high byte not driven in write");
    a_cbr_order: assert property ($fell(row_strobe_n_out) && (lo || hi) |-> $past(lo || hi))
        else $error("column strobe not ahead of row strobe");
    a_col_addr_hold: assert property (row && (lo || hi) && $past(row && (lo || hi))
        |-> $stable(mux_addr_lines_out) && $stable(write_strobe_n_out))
        else $error("address or write moved under column strobe");
    a_init_before_ready: assert property (!init_done_out |-> !req_ready_out)
        else $error("ready before init done");
    a_rd_valid_pulse: assert property (rd_valid_out |=> !rd_valid_out)
        else $error("read valid longer than one cycle");
endmodule // edc_ctrl_assertions
bind edc_ctrl edc_ctrl_assertions #(.REF_INT_CYC(REF_INT_CYC)) u_chk (.mclk_in, .rst_b_in,
    .req_ready_out, .rd_valid_out, .init_done_out, .row_strobe_n_out,
    .low_byte_col_strobe_n_out, .high_byte_col_strobe_n_out, .write_strobe_n_out,
    .out_enable_n_out, .mux_addr_lines_out, .data_lines_oe_n_out);
`default_nettype wire

// ### tb/edc_dram_model.sv
`default_nettype none
module edc_dram_model (
    // strobes and address
    input  wire logic        row_n_in,
    input  wire logic        lo_n_in,
    input  wire logic        hi_n_in,
    input  wire logic        we_n_in,
    input  wire logic        oe_n_in,
    input  wire logic [9:0]  addr_in,
    // data
    input  wire logic [15:0] din_in,
    output logic      [15:0] dout_out,
    output logic      [1:0]  drv_out,
    output int               cbr_cnt_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [bit [19:0]];
    logic [9:0]  row_q;
    logic [1:0]  sel_q = 2'h0;
    logic        cbr_q = 1'b0;
    bit   [19:0] k;
    initial cbr_cnt_out = 0;
    always @(negedge row_n_in) begin
        cbr_q = lo_n_in !== 1'b1 || hi_n_in !== 1'b1;
        if (cbr_q) cbr_cnt_out++;
        else row_q = addr_in;
    end
    // 1 ns lets both registered strobes land before the merge
    always @(negedge lo_n_in or negedge hi_n_in) begin
        #1;
        if (!row_n_in && !cbr_q) begin
            k = {row_q, addr_in};
            sel_q = ~{hi_n_in, lo_n_in};
            if (!mem.exists(k)) mem[k] = 16'h0;
            if (!we_n_in && sel_q[0]) mem[k][7:0] = din_in[7:0];
            if (!we_n_in && sel_q[1]) mem[k][15:8] = din_in[15:8];
            if (we_n_in) dout_out = mem[k];
        end
    end
    always @(posedge row_n_in) sel_q = 2'h0;
    // data held past column strobe rise until row strobe or output enable rises
    assign drv_out = {2{!row_n_in && !oe_n_in && we_n_in}} & sel_q;
endmodule // edc_dram_model
`default_nettype wire

// ### tb/edc_ctrl_bench.sv
`default_nettype none
module edc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic w; logic [19:0] a; logic [15:0] d; logic [1:0] be;
        logic pg; logic [15:0] e;} edc_row_t;
    logic mclk_in = 0, rst_b_in = 0, req_valid_in = 0, req_write_in = 0, req_page_in = 0;
    logic [19:0] req_addr_in = 0;
    logic [15:0] req_wdata_in = 0, rd_data_out, data_lines_in, data_lines_out, dout, last_q = 0;
    logic [1:0]  req_byte_en_in = 0, data_lines_oe_n_out, drv;
    logic req_ready_out, rd_valid_out, init_done_out, row_strobe_n_out, write_strobe_n_out;
    logic low_byte_col_strobe_n_out, high_byte_col_strobe_n_out, out_enable_n_out;
    logic [9:0] mux_addr_lines_out;
    int num_errors = 0, num_checks = 0, cyc = 0, n_init = 0, cbr_cnt, i;
    edc_row_t rows [9];
    always #2.5 mclk_in = ~mclk_in;
    // a released byte toggles each cycle so a stale value never reads back
    always @(posedge mclk_in) last_q <= data_lines_in;
    for (genvar b = 0; b < 2; b++) begin : g_wire
        assign data_lines_in[b*8+:8] = !data_lines_oe_n_out[b] ? data_lines_out[b*8+:8]
            : drv[b] ? dout[b*8+:8] : ~last_q[b*8+:8];
    end
    edc_ctrl #(.PWRUP_CYC(50), .REF_INT_CYC(200)) dut (.mclk_in, .rst_b_in, .req_valid_in,
        .req_write_in, .req_addr_in, .req_wdata_in, .req_byte_en_in, .req_page_in,
        .req_ready_out, .rd_valid_out, .rd_data_out, .init_done_out, .row_strobe_n_out,
        .low_byte_col_strobe_n_out, .high_byte_col_strobe_n_out, .write_strobe_n_out,
        .out_enable_n_out, .mux_addr_lines_out, .data_lines_in, .data_lines_out,
        .data_lines_oe_n_out);
    edc_dram_model u_mem (.row_n_in(row_strobe_n_out), .lo_n_in(low_byte_col_strobe_n_out),
        .hi_n_in(high_byte_col_strobe_n_out), .we_n_in(write_strobe_n_out),
        .oe_n_in(out_enable_n_out), .addr_in(mux_addr_lines_out), .din_in(data_lines_in),
        .dout_out(dout), .drv_out(drv), .cbr_cnt_out(cbr_cnt));
    always @(negedge row_strobe_n_out) if (init_done_out === 1'b0) n_init++;
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic access(input edc_row_t r);
        req_valid_in <= 1;
        req_write_in <= r.w;
        req_addr_in <= r.a;
        req_wdata_in <= r.d;
        req_byte_en_in <= r.be;
        req_page_in <= r.pg;
        do @(posedge mclk_in); while (req_ready_out !== 1'b1);
        req_valid_in <= 0;
        if (!r.w) begin
            do @(posedge mclk_in); while (rd_valid_out !== 1'b1);
            check(rd_data_out, r.e);
        end else begin
            // one idle edge keeps the next call from reassigning valid in this step
            @(posedge mclk_in);
        end
    endtask
    task automatic start();
        n_init = 0;
        repeat (2) @(posedge mclk_in);
        rst_b_in <= 1;
        do @(posedge mclk_in); while (init_done_out !== 1'b1);
        check(n_init, 8);
    endtask
    initial begin
        rows = '{'{1, 20'h00a05, 16'h1234, 2'h3, 0, 0}, '{1, 20'h00a06, 16'habcd, 2'h1, 0, 0},
            '{1, 20'h00a06, 16'h5500, 2'h2, 0, 0}, '{0, 20'h00a05, 0, 2'h3, 1, 16'h1234},
            '{0, 20'h00a06, 0, 2'h3, 1, 16'h55cd}, '{0, 20'h00a06, 0, 2'h1, 0, 16'h00cd},
            '{0, 20'h00a05, 0, 2'h2, 0, 16'h1200}, '{1, 20'h00a05, 16'hffff, 2'h0, 0, 0},
            '{0, 20'hffc00, 0, 2'h3, 0, 16'h0}};
        start();
        for (i = 0; i < 9; i++) access(rows[i]);
        access('{0, 20'h00a05, 0, 2'h3, 0, 16'h1234});
        repeat (250) @(posedge mclk_in);
        check(cbr_cnt > 0, 1);
        rst_b_in <= 0;
        @(negedge mclk_in);
        check({row_strobe_n_out, data_lines_oe_n_out, req_ready_out}, 4'he);
        start();
        access('{0, 20'h00a06, 0, 2'h3, 0, 16'h55cd});
        end_of_test();
    end
endmodule // edc_ctrl_bench
`default_nettype wire
